// ### flag_bank_defines.svh
// constants for the interrupt flag status bank: offsets, bit positions, resets
// assumes a 32-bit ahb-lite word map with one register per aligned word
`ifndef FLAG_BANK_DEFINES_SVH
`define FLAG_BANK_DEFINES_SVH

// register byte offsets
`define OFF_FLAGS_ONE   32'h0000_0000
`define OFF_FLAGS_TWO   32'h0000_0004
`define OFF_IRQ_STATUS  32'h0000_0008
`define OFF_IRQ_MASK    32'h0000_000c

// bit positions in interrupt_flags_one
`define BIT_CHANGE_NOTIFY   3
`define BIT_ONE_UNUSED      2
`define BIT_I2C_MASTER      1
`define BIT_I2C_SLAVE       0

// bit positions in interrupt_flags_two
`define BIT_TIMER_SIX       15
`define BIT_DMA_FOUR        14
`define BIT_TWO_UNUSED      13
`define BIT_OC_EIGHT        12
`define BIT_OC_SEVEN        11
`define BIT_OC_SIX          10
`define BIT_OC_FIVE         9
`define BIT_IC_SIX          8
`define BIT_IC_FIVE         7

// flags_two sits above flags_one in the combined 32-bit flag vector
`define TWO_BASE            16

// implemented bits of the combined vector {flags_two, flags_one}
`define FLAG_IMPL_MASK      32'hdf80_000b

// reset values
`define RST_FLAGS           32'h0000_0000
`define RST_IRQ_STATUS      32'h0000_0000
`define RST_IRQ_MASK        32'h0000_0000
`define RST_HRDATA          32'h0000_0000

`endif

// ### flag_bank_pkg.sv
// types for the interrupt flag status bank
// assumes flag_bank_defines.svh supplies all numeric constants
package flag_bank_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} bus_state_type;

	typedef logic [3:0] reg_sel_type;

endpackage : flag_bank_pkg

// ### flag_cell.sv
// one latched interrupt flag bit, set by hardware, read/write by software
// assumes set and write strobes come from logic on i_mclk
`timescale 1ns/1ps

module flag_cell (
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	input  wire logic i_set,
	input  wire logic i_wr,
	input  wire logic i_wdata,
	output logic      o_flag
);

	logic flag_reg;
	logic flag_next;

	// a request in the same cycle as a software write wins
	assign flag_next = i_set ? 1'b1 : (i_wr ? i_wdata : flag_reg);

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;

endmodule : flag_cell

// ### flag_bank.sv
// interrupt flag status bank with ahb-lite register slave and masked interrupt
// assumes request inputs are synchronous to i_mclk and high for each request
//
// What this block does
// - a flag reads one after its source requests, zero when none pending
// - flags_one bit 3 latches change notification requests
// - flags_one bit 2 is unimplemented: reads zero, writes ignored
// - flags_one bit 1 latches first i2c master event requests
// - flags_one bit 0 latches first i2c slave event requests
// - flags_two bit 10 latches output compare 6 requests
// - flags_two bit 9 latches output compare 5 requests
`timescale 1ns/1ps
`include "flag_bank_defines.svh"

module flag_bank
	import flag_bank_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_change_notify_req,
	input  wire logic        i_i2c_one_master_req,
	input  wire logic        i_i2c_one_slave_req,
	input  wire logic        i_timer_six_req,
	input  wire logic        i_dma_channel_four_req,
	input  wire logic        i_out_compare_eight_req,
	input  wire logic        i_out_compare_seven_req,
	input  wire logic        i_out_compare_six_req,
	input  wire logic        i_out_compare_five_req,
	input  wire logic        i_in_capture_six_req,
	input  wire logic        i_in_capture_five_req,
	output logic      [15:0] o_interrupt_flags_one,
	output logic      [15:0] o_interrupt_flags_two,
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	localparam logic [31:0] impl_mask = `FLAG_IMPL_MASK;

	function automatic reg_sel_type decode_addr(input logic [31:0] addr);
		reg_sel_type sel;
		sel    = 4'h0;
		sel[0] = (addr == `OFF_FLAGS_ONE);
		sel[1] = (addr == `OFF_FLAGS_TWO);
		sel[2] = (addr == `OFF_IRQ_STATUS);
		sel[3] = (addr == `OFF_IRQ_MASK);
		return sel;
	endfunction : decode_addr

	bus_state_type state_reg;
	bus_state_type state_next;
	reg_sel_type   sel_reg;
	reg_sel_type   sel_next;
	reg_sel_type   addr_sel;
	logic          accept;
	logic          wr_phase;
	logic          rd_load;

	assign addr_sel = decode_addr(i_haddr);
	assign accept   = i_hsel & i_htrans[1] & i_hready;
	assign wr_phase = (state_reg == BUS_WRITE);
	assign rd_load  = (state_reg == BUS_READ_WAIT);
	assign sel_next = accept ? addr_sel : sel_reg;

	////////////////////////////////////////////////////////////////////////////
	// bus state machine

	always_comb begin
		case (state_reg)
			BUS_READ_WAIT: begin
				state_next = BUS_READ_DONE;
			end
			BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
				if (accept) begin
					state_next = i_hwrite ? BUS_WRITE : BUS_READ_WAIT;
				end else begin
					state_next = BUS_IDLE;
				end
			end
			default: begin
				state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= BUS_IDLE;
			sel_reg   <= 4'h0;
		end else begin
			state_reg <= state_next;
			sel_reg   <= sel_next;
		end
	end

	assign o_hreadyout = (state_reg != BUS_READ_WAIT);
	assign o_hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// request sources placed into the combined flag vector

	logic [31:0] src_vec;

	always_comb begin
		src_vec                                      = 32'h0000_0000;
		src_vec[`BIT_CHANGE_NOTIFY]                  = i_change_notify_req;
		src_vec[`BIT_I2C_MASTER]                     = i_i2c_one_master_req;
		src_vec[`BIT_I2C_SLAVE]                      = i_i2c_one_slave_req;
		src_vec[`TWO_BASE + `BIT_TIMER_SIX]          = i_timer_six_req;
		src_vec[`TWO_BASE + `BIT_DMA_FOUR]           = i_dma_channel_four_req;
		src_vec[`TWO_BASE + `BIT_OC_EIGHT]           = i_out_compare_eight_req;
		src_vec[`TWO_BASE + `BIT_OC_SEVEN]           = i_out_compare_seven_req;
		src_vec[`TWO_BASE + `BIT_OC_SIX]             = i_out_compare_six_req;
		src_vec[`TWO_BASE + `BIT_OC_FIVE]            = i_out_compare_five_req;
		src_vec[`TWO_BASE + `BIT_IC_SIX]             = i_in_capture_six_req;
		src_vec[`TWO_BASE + `BIT_IC_FIVE]            = i_in_capture_five_req;
	end

	////////////////////////////////////////////////////////////////////////////
	// flag bits

	logic [31:0] flag_vec;
	logic        wr_one;
	logic        wr_two;

	assign wr_one = wr_phase & sel_reg[0];
	assign wr_two = wr_phase & sel_reg[1];

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (impl_mask[gi]) begin : g_impl
				flag_cell u_cell (
					.i_mclk  (i_mclk),
					.i_rstn  (i_rstn),
					.i_set   (src_vec[gi]),
					.i_wr    ((gi < 16) ? wr_one : wr_two),
					.i_wdata (i_hwdata[gi % 16]),
					.o_flag  (flag_vec[gi])
				);
			end else begin : g_none
				assign flag_vec[gi] = 1'b0;
			end
		end
	endgenerate

	assign o_interrupt_flags_one = flag_vec[15:0];
	assign o_interrupt_flags_two = flag_vec[31:16];

	////////////////////////////////////////////////////////////////////////////
	// sticky interrupt status and mask

	logic [31:0] irq_status_reg;
	logic [31:0] irq_status_next;
	logic [31:0] irq_mask_reg;
	logic [31:0] irq_mask_next;
	logic [31:0] w1c_vec;

	assign w1c_vec         = (wr_phase & sel_reg[2]) ? i_hwdata : 32'h0000_0000;
	assign irq_status_next = (irq_status_reg & ~w1c_vec) | (src_vec & impl_mask);
	assign irq_mask_next   = (wr_phase & sel_reg[3]) ? (i_hwdata & impl_mask) : irq_mask_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_status_reg <= `RST_IRQ_STATUS;
			irq_mask_reg   <= `RST_IRQ_MASK;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_mask_reg   <= irq_mask_next;
		end
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// read data

	logic [31:0] rd_val;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	assign rd_val = sel_reg[0] ? {16'h0000, flag_vec[15:0]} :
	                sel_reg[1] ? {16'h0000, flag_vec[31:16]} :
	                sel_reg[2] ? irq_status_reg :
	                sel_reg[3] ? irq_mask_reg : 32'h0000_0000;
	assign hrdata_next = rd_load ? rd_val : hrdata_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			hrdata_reg <= `RST_HRDATA;
		end else begin
			hrdata_reg <= hrdata_next;
		end
	end

	assign o_hrdata = hrdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	sequence wr_flags_one_zero;
		wr_one && (i_hwdata[15:0] == 16'h0000) && !(|src_vec[15:0]);
	endsequence

	sequence rd_flags_one;
		rd_load && sel_reg[0];
	endsequence

	chk_flag_clear_write: assert property (
		wr_flags_one_zero |=> (flag_vec[15:0] == 16'h0000))
		else $error("flags_one not cleared by a write of zero");

	chk_change_notify_latch: assert property (
		i_change_notify_req |=> o_interrupt_flags_one[`BIT_CHANGE_NOTIFY]
			##1 (o_interrupt_flags_one[`BIT_CHANGE_NOTIFY] || $past(wr_one)))
		else $error("change notify request not latched");

	chk_unused_reads_zero: assert property (
		rd_flags_one |=> (o_hrdata[`BIT_ONE_UNUSED] == 1'b0) && o_hreadyout)
		else $error("unimplemented flags_one bit read nonzero");

	chk_i2c_master_latch: assert property (
		i_i2c_one_master_req && !wr_one |=> o_interrupt_flags_one[`BIT_I2C_MASTER])
		else $error("i2c master request not latched");

	chk_i2c_slave_latch: assert property (
		i_i2c_one_slave_req ##1 wr_one |=> o_interrupt_flags_one[`BIT_I2C_SLAVE]
			== $past(i_hwdata[`BIT_I2C_SLAVE]) || $past(i_i2c_one_slave_req))
		else $error("i2c slave flag wrong after request and write");

	chk_oc_six_latch: assert property (
		i_out_compare_six_req |=> o_interrupt_flags_two[`BIT_OC_SIX]
			&& irq_status_reg[`TWO_BASE + `BIT_OC_SIX])
		else $error("output compare 6 request not latched");

	chk_oc_five_latch: assert property (
		i_out_compare_five_req && wr_two |=> o_interrupt_flags_two[`BIT_OC_FIVE])
		else $error("output compare 5 request lost against a write");

	chk_unused_two_zero: assert property (
		wr_two |=> (o_interrupt_flags_two[`BIT_TWO_UNUSED] == 1'b0)
			&& (o_interrupt_flags_two[6:0] == 7'h00))
		else $error("unimplemented flags_two bits not zero");

	sequence rd_accept;
		accept && !i_hwrite;
	endsequence

	sequence rd_answer;
		!o_hreadyout ##1 o_hreadyout;
	endsequence

	chk_read_wait_state: assert property (
		rd_accept |=> rd_answer)
		else $error("read data phase not one wait state");

	chk_flag_high_zero: assert property (
		rd_load && (sel_reg[0] || sel_reg[1]) |=> (o_hrdata[31:16] == 16'h0000))
		else $error("flag register read upper half nonzero");

	chk_flags_latch_all: assert property (
		(|src_vec) |=> ((flag_vec & $past(src_vec)) == $past(src_vec)))
		else $error("request did not set its flag");

	chk_flags_one_write: assert property (
		wr_one && !(|src_vec[15:0]) |=> ({16'h0000, o_interrupt_flags_one}
			== ($past(i_hwdata) & {16'h0000, impl_mask[15:0]})))
		else $error("flags_one write data not stored as written");

	chk_flags_two_write: assert property (
		wr_two && !(|src_vec[31:16]) |=> ({16'h0000, o_interrupt_flags_two}
			== ($past(i_hwdata) & {16'h0000, impl_mask[31:16]})))
		else $error("flags_two write data not stored as written");

	chk_status_hold: assert property (
		!(|src_vec) && !(wr_phase && sel_reg[2]) |=> $stable(irq_status_reg))
		else $error("status changed with no request or clear");

	chk_status_set_wins: assert property (
		wr_phase && sel_reg[2] && (|(src_vec & i_hwdata)) |=>
			((irq_status_reg & $past(src_vec)) == $past(src_vec)))
		else $error("status clear beat a same-cycle request");

	chk_irq_follows_set: assert property (
		(|(src_vec & irq_mask_reg)) && !(wr_phase && sel_reg[3]) |=> o_irq)
		else $error("unmasked request did not raise the interrupt");

endmodule : flag_bank

// ### req_model.sv
// model of the peripheral modules that raise interrupt requests
// assumes the bench raises one bit of i_fire for one cycle per request
`timescale 1ns/1ps

module req_model (
	input  wire logic        i_mclk,
	input  wire logic [10:0] i_fire,
	output logic      [10:0] o_req = 11'h000
);
	////////////////////////////////////////////////////////////////////////
	// one-cycle request pulse per fire, low between requests
	always @(posedge i_mclk) begin
		o_req <= i_fire;
	end
endmodule : req_model

// ### flag_bank_tb.sv
// self-checking bench for the interrupt flag status bank
// assumes the ahb-lite slave is the only slave, so hreadyout is hready
`timescale 1ns/1ps
`include "flag_bank_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end

module flag_bank_tb;
	logic        i_mclk   = 1'b0;
	logic        i_rstn   = 1'b0;
	logic        i_hsel   = 1'b0;
	logic        i_hwrite = 1'b0;
	logic [1:0]  i_htrans = 2'h0;
	logic [2:0]  i_hsize  = 3'h2;
	logic [31:0] i_haddr  = 32'h0;
	logic [31:0] i_hwdata = 32'h0;
	logic [10:0] fire     = 11'h000;
	wire  [10:0] req;
	wire  [31:0] o_hrdata;
	wire         o_hreadyout;
	wire         o_hresp;
	wire  [15:0] flags_one;
	wire  [15:0] flags_two;
	wire         o_irq;
	int          miscompares = 0;
	int          checked     = 0;
	int          cycles      = 0;
	logic [31:0] rd;
	logic [31:0] m;
	logic [31:0] v;
	localparam int POS [11] = '{3, 1, 0, 31, 30, 28, 27, 26, 25, 24, 23};

	////////////////////////////////////////////////////////////////////////
	// clock, timeout, design and request model
	always #5 i_mclk = ~i_mclk;

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	req_model u_req (.i_mclk(i_mclk), .i_fire(fire), .o_req(req));

	flag_bank u_dut (
		.i_mclk                 (i_mclk),
		.i_rstn                 (i_rstn),
		.i_hsel                 (i_hsel),
		.i_haddr                (i_haddr),
		.i_htrans               (i_htrans),
		.i_hwrite               (i_hwrite),
		.i_hsize                (i_hsize),
		.i_hwdata               (i_hwdata),
		.i_hready               (o_hreadyout),
		.o_hrdata               (o_hrdata),
		.o_hreadyout            (o_hreadyout),
		.o_hresp                (o_hresp),
		.i_change_notify_req    (req[0]),
		.i_i2c_one_master_req   (req[1]),
		.i_i2c_one_slave_req    (req[2]),
		.i_timer_six_req        (req[3]),
		.i_dma_channel_four_req (req[4]),
		.i_out_compare_eight_req(req[5]),
		.i_out_compare_seven_req(req[6]),
		.i_out_compare_six_req  (req[7]),
		.i_out_compare_five_req (req[8]),
		.i_in_capture_six_req   (req[9]),
		.i_in_capture_five_req  (req[10]),
		.o_interrupt_flags_one  (flags_one),
		.o_interrupt_flags_two  (flags_two),
		.o_irq                  (o_irq)
	);

	////////////////////////////////////////////////////////////////////////
	// bus tasks and closing report
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_hsel   <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr  <= a;
		i_hwrite <= w;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
		i_hsel <= 1'b0;
	endtask : bus

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rd)
		`CHK("hresp", 1'b0, o_hresp)
	endtask : rdchk

	task automatic pulse(input int n, input int k);
		repeat (n) @(posedge i_mclk);
		fire <= 11'h001 << k;
		@(posedge i_mclk);
		fire <= 11'h000;
	endtask : pulse

	function automatic logic [31:0] view(input logic [31:0] vec, input logic hi);
		return hi ? {16'h0000, vec[31:16]} : {16'h0000, vec[15:0]};
	endfunction : view

	task test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rd = $urandom(36004);
		repeat (20) @(posedge i_mclk);
		i_rstn <= 1'b1;
		for (int a = 0; a < 16; a += 4) rdchk(a, 32'h0, "reset value");
		`CHK("irq at reset", 1'b0, o_irq)
		$display("test reset done");
		repeat (8) begin
			v = $urandom;
			m = $urandom;
			bus(1'b1, `OFF_FLAGS_ONE, v);
			rdchk(`OFF_FLAGS_ONE, v & 32'h0000_000b, "flags_one rw");
			bus(1'b1, `OFF_FLAGS_TWO, v);
			rdchk(`OFF_FLAGS_TWO, v & 32'h0000_df80, "flags_two rw");
			rdchk(`OFF_IRQ_STATUS, 32'h0, "status untouched");
			bus(1'b1, `OFF_IRQ_MASK, m);
			rdchk(`OFF_IRQ_MASK, m & `FLAG_IMPL_MASK, "mask rw");
			rdchk(32'h0000_0010, 32'h0, "unmapped");
		end
		bus(1'b1, `OFF_FLAGS_ONE, 32'h0);
		bus(1'b1, `OFF_FLAGS_TWO, 32'h0);
		$display("test register access done");
		for (int i = 0; i < 11; i++) begin
			m = $urandom & `FLAG_IMPL_MASK;
			v = 32'h1 << POS[i];
			bus(1'b1, `OFF_IRQ_MASK, m);
			pulse(1, i);
			repeat (3) @(posedge i_mclk);
			rdchk(`OFF_FLAGS_ONE, view(v, 1'b0), "flags_one set");
			rdchk(`OFF_FLAGS_TWO, view(v, 1'b1), "flags_two set");
			`CHK("flag ports", v, {flags_two, flags_one})
			rdchk(`OFF_IRQ_STATUS, v, "status set");
			`CHK("irq masked", |(m & v), o_irq)
			bus(1'b1, `OFF_IRQ_MASK, v);
			@(posedge i_mclk);
			`CHK("irq unmasked", 1'b1, o_irq)
			bus(1'b1, `OFF_FLAGS_ONE, 32'h0);
			bus(1'b1, `OFF_FLAGS_TWO, 32'h0);
			bus(1'b1, `OFF_IRQ_STATUS, v);
			rdchk(`OFF_IRQ_STATUS, 32'h0, "status cleared");
			`CHK("flags cleared", 32'h0, {flags_two, flags_one})
			`CHK("irq cleared", 1'b0, o_irq)
		end
		$display("test requests done");
		// request lands in the write data phase: the request must win
		fork
			bus(1'b1, `OFF_FLAGS_TWO, 32'h0);
			pulse(1, 8);
		join
		rdchk(`OFF_FLAGS_TWO, 32'h0000_0200, "set beats write");
		fork
			bus(1'b1, `OFF_IRQ_STATUS, 32'hffff_ffff);
			pulse(1, 7);
		join
		rdchk(`OFF_IRQ_STATUS, 32'h0400_0000, "set beats clear");
		// request one cycle ahead of a write of zero: the write clears the flag
		fork
			bus(1'b1, `OFF_FLAGS_ONE, 32'h0);
			pulse(0, 2);
		join
		rdchk(`OFF_FLAGS_ONE, 32'h0, "write after set");
		rdchk(`OFF_IRQ_STATUS, 32'h0400_0001, "status kept");
		bus(1'b1, `OFF_IRQ_MASK, 32'hffff_ffff);
		@(posedge i_mclk);
		`CHK("irq pending", 1'b1, o_irq)
		$display("test corner cases done");
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		`CHK("irq in reset", 1'b0, o_irq)
		i_rstn <= 1'b1;
		for (int a = 0; a < 16; a += 4) rdchk(a, 32'h0, "value after reset");
		`CHK("flags after reset", 32'h0, {flags_two, flags_one})
		$display("test mid-run reset done");
		test_done();
	end
endmodule : flag_bank_tb
